/* rtl/spi_reg_slave.sv */
// spi slave giving register access through an auto-incrementing pointer
// Operation
// - four-wire or three-wire shared-line mode
// - eight-bit packets, chip select addressing
// - sample on rising clock, lines idle high
// - four commands; other command bytes ignored
// - four-wire: shift out byte at pointer
// - host writes command then data bytes
// - three-wire: command phase then data phase
// - pointer advances after each read/write
// - pointer wraps from top to zero
// - ignore traffic while chip select high
// - no timeout; transfer waits for host
// - back-to-back commands under one selection, except after a four-wire write or read
// - two reset codes reset interface only
// - set pointer loads and prefetches buffer
// - write: fetch, store, then increment
// - host treats non-read output as invalid
// - three-wire set pointer overrides increment
// - three-wire write stores then increments
// - three-wire read sends then increments
// - ignore traffic during start-up period
`timescale 1ns/10ps
module spi_reg_slave #(
  parameter int STARTUP = spi_reg_pkg::STARTUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic three_wire,
  spi_link_if.device link,
  output logic [7:0] reg_addr_ff,
  output logic [7:0] reg_wdata_ff,
  output logic reg_we_ff,
  output logic ready_ff
);
  typedef enum logic [1:0] {ST_CMD, ST_PTR, ST_WR, ST_RD} phase_t;
  logic [7:0] regs [spi_reg_pkg::NUM_REGS];
  logic sclk_s, cs_n_s, mosi_s, sdio_s, mode_s;
  logic sclk_d_ff;
  logic [31:0] boot_ff;
  phase_t phase_ff;
  logic [2:0] bitcnt_ff;
  logic [7:0] shin_ff;
  logic [7:0] shout_ff;
  logic [7:0] ptr_ff;
  logic last_rst_ff;
  logic armed_ff;
  logic miso_ff, sdo_ff, sdoe_ff;
  // pins cross into clk_sys through two flops; edges are found after them
  sync_2ff #(.W(5), .INIT(5'h1f)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({link.sclk, link.cs_n, link.mosi, link.shared_bidir_data_line,
        three_wire}),
    .q({sclk_s, cs_n_s, mosi_s, sdio_s, mode_s})
  );
  // a selection still open when start-up ends is ignored until it closes,
  // so the first bit taken is always the first of a byte
  wire active = ready_ff && armed_ff && !cs_n_s;
  wire rise = active && sclk_s && !sclk_d_ff;
  wire fall = active && !sclk_s && sclk_d_ff;
  wire din = mode_s ? sdio_s : mosi_s;
  wire [7:0] byte_in = {shin_ff[6:0], din};
  wire byte_done = rise && (bitcnt_ff == 3'd7);
  // three-wire: the slave drives the shared line only in a read's data byte
  wire rd_drive = mode_s && phase_ff == ST_RD;
  // the slave's own read data on the shared line never counts as a code
  wire is_rst = !rd_drive && byte_in == spi_reg_pkg::CMD_RESET;
  wire dbl_rst = byte_done && is_rst && last_rst_ff;
  wire [7:0] ptr_inc = ptr_ff + 8'h01;
  wire [7:0] cur_reg = regs[ptr_ff];
  wire store = byte_done && !dbl_rst && phase_ff == ST_WR;
  // next phase after a byte; unknown command bytes stay in ST_CMD
  wire cmd_ptr = byte_in == spi_reg_pkg::CMD_SET_PTR;
  wire cmd_wr = byte_in == spi_reg_pkg::CMD_WRITE;
  wire cmd_rd = byte_in == spi_reg_pkg::CMD_READ;
  phase_t nxt_phase;
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      ST_CMD: begin
        if (cmd_ptr) begin
          nxt_phase = ST_PTR;
        end else if (cmd_wr) begin
          nxt_phase = ST_WR;
        end else if (cmd_rd) begin
          nxt_phase = ST_RD;
        end else begin
          nxt_phase = ST_CMD;
        end
      end
      ST_PTR: nxt_phase = ST_CMD;
      // three-wire: one data phase per command; four-wire keeps streaming
      ST_WR: nxt_phase = mode_s ? ST_CMD : ST_WR;
      ST_RD: nxt_phase = mode_s ? ST_CMD : ST_RD;
      default: nxt_phase = ST_CMD;
    endcase
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b1;
      boot_ff <= '0;
      ready_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      if (ready_ff && cs_n_s) begin
        armed_ff <= 1'b1;
      end
      // start-up count; ready then stays set until the next reset
      if (boot_ff == 32'(STARTUP - 1)) begin
        ready_ff <= 1'b1;
      end else begin
        boot_ff <= boot_ff + 32'd1;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ff <= ST_CMD;
      bitcnt_ff <= 3'd0;
      shin_ff <= spi_reg_pkg::BYTE_IDLE;
      last_rst_ff <= 1'b0;
    end else if (cs_n_s || dbl_rst) begin
      // deselect or double reset code: interface back to idle
      phase_ff <= ST_CMD;
      bitcnt_ff <= 3'd0;
      last_rst_ff <= 1'b0;
    end else if (rise) begin
      shin_ff <= byte_in;
      bitcnt_ff <= bitcnt_ff + 3'd1;
      if (byte_done) begin
        last_rst_ff <= is_rst;
        phase_ff <= nxt_phase;
      end
    end
  end
  // pointer and register store, all at the last bit's rising edge
  // the store uses the old pointer, the increment lands at the same edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_ff <= spi_reg_pkg::PTR_RESET;
      reg_we_ff <= 1'b0;
      reg_addr_ff <= spi_reg_pkg::PTR_RESET;
      reg_wdata_ff <= spi_reg_pkg::REG_RESET;
    end else begin
      reg_we_ff <= 1'b0;
      if (byte_done && !dbl_rst) begin
        case (phase_ff)
          ST_PTR: ptr_ff <= byte_in;
          ST_WR: begin
            reg_we_ff <= 1'b1;
            reg_addr_ff <= ptr_ff;
            reg_wdata_ff <= byte_in;
            ptr_ff <= ptr_inc;
          end
          ST_RD: ptr_ff <= ptr_inc;
          default: ptr_ff <= ptr_ff;
        endcase
      end
    end
  end
  // the array has no reset; a register reads unknown until written
  always_ff @(posedge clk_sys) begin
    if (store) begin
      regs[ptr_ff] <= byte_in;
    end
  end
  // output shifter: reloads from the pointer's register each byte
  wire [7:0] load_val = (byte_done && phase_ff == ST_PTR) ? regs[byte_in] :
                        (byte_done && phase_ff != ST_CMD) ? regs[ptr_inc] :
                        cur_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shout_ff <= spi_reg_pkg::BYTE_IDLE;
    end else if (!active) begin
      shout_ff <= cur_reg;
    end else if (byte_done) begin
      shout_ff <= load_val;
    end else if (fall) begin
      shout_ff <= {shout_ff[6:0], 1'b1};
    end
  end
  // next bit out on the falling edge, taken by host half a period after the rise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      miso_ff <= 1'b1;
      sdo_ff <= 1'b1;
      sdoe_ff <= 1'b0;
    end else if (!active) begin
      // released lines go back to their idle high level
      miso_ff <= 1'b1;
      sdo_ff <= 1'b1;
      sdoe_ff <= 1'b0;
    end else if (byte_done) begin
      sdoe_ff <= 1'b0;
    end else if (fall) begin
      miso_ff <= shout_ff[7];
      sdo_ff <= shout_ff[7];
      sdoe_ff <= rd_drive;
    end
  end
  assign link.miso = miso_ff;
  assign link.sdio_s_out = sdo_ff;
  assign link.sdio_s_oe = sdoe_ff;
endmodule : spi_reg_slave

/* rtl/spi_reg_pkg.sv */
// shared constants for the spi register access link
package spi_reg_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int NUM_REGS = 256;
  localparam logic [7:0] CMD_RESET = 8'h7a;
  localparam logic [7:0] CMD_SET_PTR = 8'h7d;
  localparam logic [7:0] CMD_WRITE = 8'h7e;
  localparam logic [7:0] CMD_READ = 8'h7f;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BYTE_IDLE = 8'hff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_MS = 15;
  localparam int STARTUP_CYCLES = STARTUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 4;
  localparam int CS_GAP_CYCLES = 8;
endpackage : spi_reg_pkg

/* rtl/spi_link_if.sv */
// spi link wires between the register slave and its host
`timescale 1ns/10ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic sdio_m_out;
  logic sdio_m_oe;
  logic sdio_s_out;
  logic sdio_s_oe;
  logic shared_bidir_data_line;
  // shared line idles high through a pull-up when nobody drives
  assign shared_bidir_data_line = sdio_m_oe ? sdio_m_out :
                                  sdio_s_oe ? sdio_s_out : 1'b1;
  modport device (input sclk, input cs_n, input mosi, output miso,
                  input shared_bidir_data_line, output sdio_s_out,
                  output sdio_s_oe);
  modport host (output sclk, output cs_n, output mosi, input miso,
                input shared_bidir_data_line, output sdio_m_out,
                output sdio_m_oe);
endinterface : spi_link_if

/* rtl/sync_2ff.sv */
// two flip-flop level synchroniser, width parameterised
`timescale 1ns/10ps
module sync_2ff #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule : sync_2ff

/* rtl/spi_reg_host.sv */
// spi master issuing one command byte plus an optional data byte per request
`timescale 1ns/10ps
module spi_reg_host #(
  parameter int HALF = spi_reg_pkg::SCLK_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic three_wire,
  input wire logic req,
  input wire logic [7:0] cmd,
  input wire logic [7:0] wdata,
  input wire logic has_data,
  input wire logic data_out,
  output logic busy_ff,
  output logic done_ff,
  output logic [7:0] rdata_ff,
  spi_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_XFER, H_GAP} hstate_t;
  hstate_t st_ff;
  logic [7:0] div_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff, rx_ff;
  logic sclk_ff, cs_n_ff, mosi_ff, oe_ff, second_ff, dout_ff, hasd_ff;
  logic [7:0] dat_ff;
  logic miso_s, sdio_s;
  sync_2ff #(.W(2), .INIT(2'h3)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({link.miso, link.shared_bidir_data_line}),
    .q({miso_s, sdio_s})
  );
  wire tick = div_ff == 8'(HALF - 1);
  wire din = three_wire ? sdio_s : miso_s;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= H_IDLE;
      div_ff <= '0;
      bit_ff <= '0;
      sh_ff <= spi_reg_pkg::BYTE_IDLE;
      rx_ff <= '0;
      dat_ff <= '0;
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b1;
      oe_ff <= 1'b0;
      second_ff <= 1'b0;
      dout_ff <= 1'b1;
      hasd_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      div_ff <= tick ? 8'd0 : div_ff + 8'd1;
      case (st_ff)
        H_IDLE: begin
          div_ff <= '0;
          if (req) begin
            st_ff <= H_XFER;
            busy_ff <= 1'b1;
            cs_n_ff <= 1'b0;
            sh_ff <= cmd;
            dat_ff <= wdata;
            hasd_ff <= has_data;
            dout_ff <= data_out;
            second_ff <= 1'b0;
            bit_ff <= '0;
            mosi_ff <= cmd[7];
            oe_ff <= three_wire;
          end
        end
        H_XFER: if (tick) begin
          sclk_ff <= ~sclk_ff;
          if (!sclk_ff) begin
            bit_ff <= bit_ff + 4'd1;
            sh_ff <= {sh_ff[6:0], 1'b1};
            if (bit_ff == 4'd7) begin
              if (!second_ff && hasd_ff) begin
                second_ff <= 1'b1;
                bit_ff <= '0;
                sh_ff <= dat_ff;
              end else begin
                st_ff <= H_GAP;
              end
            end
          end else begin
            // the slave's bit needs two flops to arrive, so it is taken
            // one half period late, just before the next bit goes out
            rx_ff <= {rx_ff[6:0], din};
            mosi_ff <= sh_ff[7];
            oe_ff <= three_wire && !(second_ff && !dout_ff);
          end
        end
        H_GAP: begin
          cs_n_ff <= 1'b1;
          oe_ff <= 1'b0;
          mosi_ff <= 1'b1;
          if (tick) begin
            st_ff <= H_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            // last bit; only a read's byte is meaningful to the user
            rdata_ff <= {rx_ff[6:0], din};
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;
  assign link.sdio_m_out = mosi_ff;
  assign link.sdio_m_oe = oe_ff;
endmodule : spi_reg_host

/* tb/spi_link_assertions.sv */
// interface checks on the link between register host and slave
`timescale 1ns/10ps
module spi_link_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sdio_m_out,
  input wire logic sdio_m_oe,
  input wire logic sdio_s_out,
  input wire logic sdio_s_oe,
  input wire logic shared_bidir_data_line
);
  logic sclk_q_ff;
  logic [4:0] rise_cnt_ff;
  logic [4:0] nxt_rise_cnt;
  assign nxt_rise_cnt = cs_n ? 5'h00 : rise_cnt_ff + 5'(sclk & ~sclk_q_ff);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q_ff <= 1'b1;
      rise_cnt_ff <= 5'h00;
    end else begin
      sclk_q_ff <= sclk;
      rise_cnt_ff <= nxt_rise_cnt;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  AST_CS_SCLK_IDLE: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  AST_NO_CONTENTION: assert property (!(sdio_m_oe && sdio_s_oe))
    else $error("both ends drive the shared line");
  AST_SLAVE_OE_IDLE: assert property (cs_n [*8] |-> !sdio_s_oe)
    else $error("slave drives while deselected");
  AST_MASTER_OE_IDLE: assert property (cs_n [*2] |-> !sdio_m_oe)
    else $error("host drives shared line while deselected");
  AST_MISO_IDLE: assert property (cs_n [*8] |-> miso)
    else $error("output line not idle high");
  AST_SHARED_IDLE: assert property (cs_n [*8] |-> shared_bidir_data_line)
    else $error("shared line not idle high");
  AST_SLAVE_OUT_STABLE: assert property ($rose(sclk) && sdio_s_oe
    |=> $stable(sdio_s_out) [*2])
    else $error("slave data moved at sampling edge");
  AST_FRAME_LEN: assert property ($rose(cs_n)
    |-> (rise_cnt_ff == 5'h08 || rise_cnt_ff == 5'h10))
    else $error("selection not a whole number of bytes");
endmodule : spi_link_assertions

/* tb/testbench.sv */
// self-checking bench joining the spi register host and slave
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic three_wire = 1'b0;
  logic req = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic has_data = 1'b1;
  logic data_out = 1'b1;
  logic busy, done, reg_we, ready, wire_bit;
  logic [7:0] rdata, reg_addr, reg_wdata;
  logic [15:0] mon_sh;
  int mon_n, we_n, n_fail, num_checks, cyc;
  spi_link_if link_bus ();
  spi_reg_slave #(.STARTUP(400)) u_spi_reg_slave (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .three_wire(three_wire), .link(link_bus.device),
    .reg_addr_ff(reg_addr), .reg_wdata_ff(reg_wdata), .reg_we_ff(reg_we),
    .ready_ff(ready));
  spi_reg_host u_spi_reg_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .three_wire(three_wire), .req(req), .cmd(cmd), .wdata(wdata),
    .has_data(has_data), .data_out(data_out), .busy_ff(busy),
    .done_ff(done), .rdata_ff(rdata), .link(link_bus.host));
  spi_link_assertions u_spi_link_assertions (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .sclk(link_bus.sclk), .cs_n(link_bus.cs_n),
    .mosi(link_bus.mosi), .miso(link_bus.miso),
    .sdio_m_out(link_bus.sdio_m_out), .sdio_m_oe(link_bus.sdio_m_oe),
    .sdio_s_out(link_bus.sdio_s_out), .sdio_s_oe(link_bus.sdio_s_oe),
    .shared_bidir_data_line(link_bus.shared_bidir_data_line));
  assign wire_bit = three_wire ? link_bus.shared_bidir_data_line
                               : link_bus.mosi;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // records the bits each selection carries, as sampled on rising clock
  always @(posedge link_bus.sclk) begin
    if (link_bus.cs_n === 1'b0) begin
      mon_sh = {mon_sh[14:0], wire_bit};
      mon_n++;
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (reg_we === 1'b1) we_n++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask : chk
  task automatic xfer(input logic [7:0] c, d, input logic dout,
                      input logic [7:0] exp_d);
    int i;
    mon_n = 0;
    @(negedge clk_sys);
    req = 1'b1;
    cmd = c;
    wdata = d;
    data_out = dout;
    @(negedge clk_sys);
    req = 1'b0;
    chk("busy", 16'(busy), 16'h0001);
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk_sys);
    chk("done", 16'(done), 16'h0001);
    chk("idle", 16'(busy), 16'h0000);
    chk("bits", 16'(mon_n), 16'h0010);
    chk("wire", mon_sh, {c, exp_d});
    repeat (4) @(negedge clk_sys);
  endtask : xfer
  task automatic wr(input logic [7:0] d, a);
    int n0;
    n0 = we_n;
    xfer(spi_reg_pkg::CMD_WRITE, d, 1'b1, d);
    chk("stores", 16'(we_n - n0), 16'h0001);
    chk("addr", 16'(reg_addr), 16'(a));
    chk("wdata", 16'(reg_wdata), 16'(d));
  endtask : wr
  task automatic rd(input logic [7:0] e);
    xfer(spi_reg_pkg::CMD_READ, 8'hff, !three_wire, three_wire ? e : 8'hff);
    chk("rdata", 16'(rdata), 16'(e));
  endtask : rd
  task automatic setp(input logic [7:0] a);
    xfer(spi_reg_pkg::CMD_SET_PTR, a, 1'b1, a);
  endtask : setp
  task automatic t_startup;
    xfer(spi_reg_pkg::CMD_WRITE, 8'h11, 1'b1, 8'h11);
    chk("early", 16'(we_n), 16'h0000);
    for (int i = 0; i < 600 && ready !== 1'b1; i++) @(negedge clk_sys);
    chk("ready", 16'(ready), 16'h0001);
  endtask : t_startup
  task automatic t_four;
    setp(8'hfe);
    wr(8'ha5, 8'hfe);
    wr(8'h3c, 8'hff);
    wr(8'h5a, 8'h00);
    setp(8'hfe);
    rd(8'ha5);
    rd(8'h3c);
    rd(8'h5a);
  endtask : t_four
  task automatic t_codes;
    int n0;
    n0 = we_n;
    xfer(8'h55, 8'h22, 1'b1, 8'h22);
    xfer(spi_reg_pkg::CMD_RESET, spi_reg_pkg::CMD_RESET, 1'b1,
         spi_reg_pkg::CMD_RESET);
    chk("ignored", 16'(we_n - n0), 16'h0000);
    setp(8'hff);
    rd(8'h3c);
  endtask : t_codes
  task automatic t_three;
    three_wire = 1'b1;
    repeat (4) @(negedge clk_sys);
    setp(8'h10);
    wr(8'h99, 8'h10);
    wr(8'h66, 8'h11);
    setp(8'h10);
    rd(8'h99);
    rd(8'h66);
  endtask : t_three
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_startup();
    t_four();
    t_codes();
    t_three();
    end_sim();
  end
endmodule : testbench
